// >>> verilog/baud_timer_pkg.sv
// constants and register map of the capture / reload / baud timer
// Summary of operation
// [RULE1] one 16-bit up-counter of low and high byte, both software readable and writable
// [RULE2] source_select clear: count system clock divided by one or twelve per prescale_select
// [RULE3] source_select set: count once per falling edge on ext_count_pin
// [RULE4] no baud select and running: capture_reload_select picks capture or auto-reload
// [RULE5] run_control starts counting; cleared, the timer is off whatever the mode bits
// [RULE6] capture mode, trigger enabled: trigger fall copies count, sets event flag, interrupts
// [RULE7] capture and reload modes ignore trigger pin while ext_trigger_enable is clear
// [RULE8] capture and reload modes: rollover ffff to 0 sets overflow_flag and interrupts
// [RULE9] auto-reload mode: each overflow loads the reload pair and counting goes on
// [RULE10] auto-reload mode, trigger enabled: trigger fall forces reload and interrupts
// [RULE11] any baud select set: auto-reload for baud, capture_reload_select ignored
// [RULE12] baud mode overflows set no flag, no interrupt; they tick the serial shift clock
// [RULE13] baud mode, internal source: count at half system clock, rate clk/((65536-rl)*32)
// [RULE14] baud mode, pin source: count ext_count_pin edges, rate f/((65536-rl)*16)
// [RULE15] baud mode, trigger enabled: trigger fall sets event flag and interrupts
// [RULE16] overflows chosen independently as transmit and receive baud clock
// [RULE17] the serial port uses these overflows only in its variable-rate modes 1 or 3
// [RULE18] a timer event output lets the converter start a conversion
// [RULE19] both flags stay set until software clears them
package baud_timer_pkg;
  localparam int unsigned ADDR_WIDTH = 5;
  localparam logic [ADDR_WIDTH-1:0] CONTROL_OFFSET = 5'h00;
  localparam logic [ADDR_WIDTH-1:0] COUNT_OFFSET = 5'h04;
  localparam logic [ADDR_WIDTH-1:0] RELOAD_OFFSET = 5'h08;
  localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET = 5'h0c;
  localparam logic [ADDR_WIDTH-1:0] MASK_OFFSET = 5'h10;
  // control register fields
  localparam int unsigned CAPTURE_RELOAD_BIT = 0;
  localparam int unsigned SOURCE_BIT = 1;
  localparam int unsigned RUN_BIT = 2;
  localparam int unsigned TRIGGER_ENABLE_BIT = 3;
  localparam int unsigned TX_BAUD_BIT = 4;
  localparam int unsigned RX_BAUD_BIT = 5;
  localparam int unsigned PRESCALE_BIT = 6;
  localparam int unsigned CONTROL_WIDTH = 7;
  localparam logic [CONTROL_WIDTH-1:0] CONTROL_RESET = 7'h00;
  // status / mask fields
  localparam int unsigned OVERFLOW_BIT = 0;
  localparam int unsigned EXT_EVENT_BIT = 1;
  localparam int unsigned STATUS_WIDTH = 2;
  localparam logic [STATUS_WIDTH-1:0] STATUS_RESET = 2'h0;
  localparam logic [STATUS_WIDTH-1:0] MASK_RESET = 2'h0;
  // prescaler: system clock divided by twelve, counter wraps at its last value
  localparam logic [3:0] PRESCALE_LAST = 4'hb;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : baud_timer_pkg

// >>> verilog/capture_reload_baud_timer.sv
// 16-bit capture / auto-reload / baud rate timer with an AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module capture_reload_baud_timer
  import baud_timer_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_pin,
  input wire logic ext_trigger_pin,
  output logic tx_baud_tick,
  output logic rx_baud_tick,
  output logic adc_trigger,
  output logic irq
);

  localparam logic [COUNT_WIDTH-1:0] COUNT_ALL_ONES = {COUNT_WIDTH{1'b1}};
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = {{(COUNT_WIDTH-1){1'b0}}, 1'b1};

  logic [CONTROL_WIDTH-1:0] control_reg;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] reload_reg;
  logic [STATUS_WIDTH-1:0] status_reg;
  logic [STATUS_WIDTH-1:0] status_next;
  logic [STATUS_WIDTH-1:0] mask_reg;
  logic [3:0] prescale_reg;
  logic [2:0] count_pin_sync_reg;
  logic [2:0] trigger_sync_reg;
  logic [ADDR_WIDTH-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // ---------------------------------------------------------------- bus slave
  logic wr_en;
  logic ctrl_wr;
  logic count_wr;
  logic reload_wr;
  logic status_wr;
  logic mask_wr;
  logic wr_mapped;

  // a write fires once, when address and data are both held and no response is pending
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign ctrl_wr = wr_en && (awaddr_reg == CONTROL_OFFSET);
  assign count_wr = wr_en && (awaddr_reg == COUNT_OFFSET) && (wstrb_reg[1:0] != 2'h0);
  assign reload_wr = wr_en && (awaddr_reg == RELOAD_OFFSET);
  assign status_wr = wr_en && (awaddr_reg == STATUS_OFFSET);
  assign mask_wr = wr_en && (awaddr_reg == MASK_OFFSET);
  assign wr_mapped = (awaddr_reg == CONTROL_OFFSET) || (awaddr_reg == COUNT_OFFSET) ||
                     (awaddr_reg == RELOAD_OFFSET) || (awaddr_reg == STATUS_OFFSET) ||
                     (awaddr_reg == MASK_OFFSET);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_wready <= 1'b1;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        CONTROL_OFFSET: s_axi_rdata <= 32'(control_reg);
        COUNT_OFFSET: s_axi_rdata <= 32'(count_reg); // RULE1
        RELOAD_OFFSET: s_axi_rdata <= 32'(reload_reg);
        STATUS_OFFSET: s_axi_rdata <= 32'(status_reg);
        MASK_OFFSET: s_axi_rdata <= 32'(mask_reg);
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------- control and mode decode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      control_reg <= CONTROL_RESET;
    end else if (ctrl_wr && wstrb_reg[0]) begin
      control_reg <= wdata_reg[CONTROL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= MASK_RESET;
    end else if (mask_wr && wstrb_reg[0]) begin
      mask_reg <= wdata_reg[STATUS_WIDTH-1:0];
    end
  end

  logic run;
  logic baud_mode;
  logic capture_mode;
  logic trigger_enable;

  assign run = control_reg[RUN_BIT]; // RULE5
  assign baud_mode = control_reg[TX_BAUD_BIT] || control_reg[RX_BAUD_BIT]; // RULE11
  // RULE4
  assign capture_mode = !baud_mode && control_reg[CAPTURE_RELOAD_BIT];
  assign trigger_enable = control_reg[TRIGGER_ENABLE_BIT];

  // ---------------------------------------------------------------- pin synchronisers
  // stage 0 feeds stage 1 only; edges are seen between stages 1 and 2
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_pin_sync_reg <= 3'h7;
      trigger_sync_reg <= 3'h7;
    end else begin
      count_pin_sync_reg <= {count_pin_sync_reg[1:0], ext_count_pin};
      trigger_sync_reg <= {trigger_sync_reg[1:0], ext_trigger_pin};
    end
  end

  logic count_pin_fall;
  logic trigger_fall;

  assign count_pin_fall = count_pin_sync_reg[2] && !count_pin_sync_reg[1]; // RULE3
  assign trigger_fall = trigger_sync_reg[2] && !trigger_sync_reg[1];

  // ---------------------------------------------------------------- prescaler
  // free running, so a tick phase does not depend on when run_control was set
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prescale_reg <= 4'h0;
    end else if (prescale_reg == PRESCALE_LAST) begin
      prescale_reg <= 4'h0;
    end else begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end

  logic sys_tick;
  logic tick;
  logic overflow;
  logic trigger_event;
  logic reload_now;

  // bit 0 alternates since the prescaler has an even number of states
  always_comb begin
    if (baud_mode) begin
      sys_tick = prescale_reg[0]; // RULE13
    end else if (control_reg[PRESCALE_BIT]) begin
      sys_tick = 1'b1; // RULE2
    end else begin
      sys_tick = (prescale_reg == PRESCALE_LAST); // RULE2
    end
  end

  // RULE3 RULE14
  assign tick = run && (control_reg[SOURCE_BIT] ? count_pin_fall : sys_tick);
  // a software count write in the same cycle wins over counting
  assign overflow = tick && (count_reg == COUNT_ALL_ONES) && !count_wr;
  // RULE7
  assign trigger_event = run && trigger_enable && trigger_fall;
  // RULE9 RULE10 RULE11
  assign reload_now = !capture_mode && (overflow || (trigger_event && !baud_mode));

  // ---------------------------------------------------------------- counter
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
    end else if (count_wr) begin
      if (wstrb_reg[0]) begin
        count_reg[7:0] <= wdata_reg[7:0]; // RULE1
      end
      if (wstrb_reg[1]) begin
        count_reg[COUNT_WIDTH-1:8] <= wdata_reg[COUNT_WIDTH-1:8]; // RULE1
      end
    end else if (reload_now) begin
      count_reg <= reload_reg; // RULE9 RULE10
    end else if (tick) begin
      count_reg <= count_reg + COUNT_ONE; // RULE5
    end
  end

  // capture wins over a software write to the pair in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reload_reg <= '0;
    end else if (capture_mode && trigger_event) begin
      reload_reg <= count_reg; // RULE6
    end else if (reload_wr) begin
      if (wstrb_reg[0]) begin
        reload_reg[7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        reload_reg[COUNT_WIDTH-1:8] <= wdata_reg[COUNT_WIDTH-1:8];
      end
    end
  end

  // ---------------------------------------------------------------- flags and interrupt
  logic [STATUS_WIDTH-1:0] status_set;
  logic [STATUS_WIDTH-1:0] status_clear;

  always_comb begin
    status_set = '0;
    status_set[OVERFLOW_BIT] = overflow && !baud_mode; // RULE8 RULE12
    status_set[EXT_EVENT_BIT] = trigger_event; // RULE6 RULE10 RULE15
    status_clear = (status_wr && wstrb_reg[0]) ? wdata_reg[STATUS_WIDTH-1:0] : '0;
    // hardware set wins over a write-one-to-clear in the same cycle
    status_next = (status_reg & ~status_clear) | status_set; // RULE19
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next; // RULE19
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & mask_reg); // RULE6 RULE8 RULE15
    end
  end

  // ---------------------------------------------------------------- event outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_baud_tick <= 1'b0;
      rx_baud_tick <= 1'b0;
      adc_trigger <= 1'b0;
    end else begin
      tx_baud_tick <= overflow && control_reg[TX_BAUD_BIT]; // RULE12 RULE16
      rx_baud_tick <= overflow && control_reg[RX_BAUD_BIT]; // RULE12 RULE16
      adc_trigger <= overflow; // RULE18
    end
  end

  // ---------------------------------------------------------------- assertions
  property p_run_off;
    @(posedge clock) disable iff (!arst_n)
      (!run && !count_wr) |=> (count_reg == $past(count_reg));
  endproperty
  a_run_off: assert property (p_run_off) else $error("counter moved while stopped"); // RULE5

  property p_ext_count;
    @(posedge clock) disable iff (!arst_n)
      (run && control_reg[SOURCE_BIT] && count_pin_fall && !count_wr &&
       (count_reg != COUNT_ALL_ONES) && !trigger_event)
      |=> (count_reg == $past(count_reg) + COUNT_ONE);
  endproperty
  a_ext_count: assert property (p_ext_count) else $error("pin edge did not count"); // RULE3

  property p_overflow_flag;
    @(posedge clock) disable iff (!arst_n)
      (overflow && !baud_mode) |=>
        status_reg[OVERFLOW_BIT] ##1 (status_reg[OVERFLOW_BIT] || $past(status_wr));
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag not set"); // RULE8

  property p_baud_no_flag;
    @(posedge clock) disable iff (!arst_n)
      (baud_mode && !status_reg[OVERFLOW_BIT]) |=> !status_reg[OVERFLOW_BIT];
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag) else $error("flag set in baud mode"); // RULE12

  property p_reload;
    @(posedge clock) disable iff (!arst_n)
      (overflow && !capture_mode) |=> (count_reg == $past(reload_reg));
  endproperty
  a_reload: assert property (p_reload) else $error("overflow did not reload"); // RULE9

  property p_capture;
    @(posedge clock) disable iff (!arst_n)
      (capture_mode && trigger_event) |=>
        (reload_reg == $past(count_reg)) && status_reg[EXT_EVENT_BIT];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed"); // RULE6

  property p_trigger_ignored;
    @(posedge clock) disable iff (!arst_n)
      (!trigger_enable && !status_reg[EXT_EVENT_BIT]) |=> !status_reg[EXT_EVENT_BIT];
  endproperty
  a_trigger_ignored: assert property (p_trigger_ignored) else $error("trigger not ignored"); // RULE7

  property p_sticky;
    @(posedge clock) disable iff (!arst_n)
      (status_reg[EXT_EVENT_BIT] && !status_wr) |=> status_reg[EXT_EVENT_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by hardware"); // RULE19

  property p_tx_tick;
    @(posedge clock) disable iff (!arst_n)
      (overflow && control_reg[TX_BAUD_BIT]) |=> tx_baud_tick && adc_trigger;
  endproperty
  a_tx_tick: assert property (p_tx_tick) else $error("transmit tick missing"); // RULE16

  property p_irq;
    @(posedge clock) disable iff (!arst_n)
      (trigger_event && mask_reg[EXT_EVENT_BIT]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // RULE15

  property p_rx_tick;
    @(posedge clock) disable iff (!arst_n)
      (overflow && control_reg[RX_BAUD_BIT]) |=> rx_baud_tick && adc_trigger;
  endproperty
  a_rx_tick: assert property (p_rx_tick) else $error("receive tick missing"); // RULE16

  // a trigger in baud mode only flags; reloading would upset the serial bit timing
  property p_baud_trigger;
    @(posedge clock) disable iff (!arst_n)
      (baud_mode && trigger_event && !tick && !count_wr) |=>
        (count_reg == $past(count_reg)) && status_reg[EXT_EVENT_BIT];
  endproperty
  a_baud_trigger: assert property (p_baud_trigger) else $error("baud trigger misbehaved"); // RULE15

endmodule : capture_reload_baud_timer
`default_nettype wire

// >>> tb/uart_tick_model.sv
// partner model: serial port shift clock that consumes the timer overflow ticks
`timescale 1ns/1ns
`default_nettype none
module uart_tick_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tx_baud_tick,
  input wire logic rx_baud_tick,
  input wire logic [1:0] uart_mode,
  input wire logic clear,
  output logic [15:0] tx_count,
  output logic [15:0] rx_count
);
  // fixed-rate modes run from their own divider, so ticks there are dropped
  wire logic var_rate = (uart_mode == 2'h1) || (uart_mode == 2'h3);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_count <= 16'h0000;
      rx_count <= 16'h0000;
    end else if (clear) begin
      tx_count <= 16'h0000;
      rx_count <= 16'h0000;
    end else if (var_rate) begin
      tx_count <= tx_count + {15'h0000, tx_baud_tick};
      rx_count <= rx_count + {15'h0000, rx_baud_tick};
    end
  end
endmodule : uart_tick_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench of the capture / reload / baud timer
`timescale 1ns/1ns
`default_nettype none
module tb;
  import baud_timer_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_WIDTH-1:0] awaddr = 5'h00, araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic cpin = 1'b1, tpin = 1'b1, clr = 1'b0;
  logic [31:0] wdata = 32'h0, d, r, k;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] umode = 2'h1, resp;
  wire logic awready, wready, bvalid, arready, rvalid, txt, rxt, adc, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] txn, rxn;
  int err_count = 0, num_checks = 0, adc_n = 0;
  always #10 clock = ~clock;
  always @(posedge clock) if (adc === 1'b1) adc_n <= adc_n + 1;
  capture_reload_baud_timer uut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_count_pin(cpin), .ext_trigger_pin(tpin), .tx_baud_tick(txt),
    .rx_baud_tick(rxt), .adc_trigger(adc), .irq(irq));
  uart_tick_model serial (.clock(clock), .arst_n(arst_n), .tx_baud_tick(txt),
    .rx_baud_tick(rxt), .uart_mode(umode), .clear(clr), .tx_count(txn), .rx_count(rxn));
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task tmo;
    err_count++;
    $display("[ERR] %0t wait limit used up", $time);
    results();
  endtask : tmo
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // address and data are offered together and each dropped once taken
  task wr(input logic [4:0] a, input logic [31:0] dv, input logic [3:0] s = 4'hf);
    int i;
    @(posedge clock);
    awaddr <= a;
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (i == 40) tmo();
  endtask : wr
  task rd(input logic [4:0] a);
    int i;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (i == 40) tmo();
  endtask : rd
  task rchk(input logic [4:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask : rchk
  // long enough for the two-stage synchroniser and edge stage on both edges
  task pin_fall(input logic trig);
    if (trig) tpin <= 1'b0;
    else cpin <= 1'b0;
    cyc(4);
    tpin <= 1'b1;
    cpin <= 1'b1;
    cyc(4);
  endtask : pin_fall
  function automatic logic [31:0] ticks(input int n, input logic [15:0] rl);
    return n / (32'h10000 - {16'h0000, rl});
  endfunction : ticks
  function automatic logic [31:0] inr(input int lo, input int hi, input logic [31:0] v);
    return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
  endfunction : inr
  initial begin
    void'($urandom(97));
    cyc(5);
    arst_n <= 1'b1;
    for (int a = 0; a < 5; a++) rchk(5'(a * 4), 32'h0);
    rd(5'h14);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(5'h14, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(COUNT_OFFSET, 32'ha5c3);
    rchk(COUNT_OFFSET, 32'ha5c3);
    wr(COUNT_OFFSET, 32'h00ff, 4'h1);
    rchk(COUNT_OFFSET, 32'ha5ff);
    wr(CONTROL_OFFSET, 32'h48);
    cyc(30);
    pin_fall(1'b1);
    rchk(COUNT_OFFSET, 32'ha5ff);
    rchk(STATUS_OFFSET, 32'h0);
    $display("test registers and idle done");
    for (int p = 0; p < 2; p++) begin
      wr(COUNT_OFFSET, 32'h0);
      wr(CONTROL_OFFSET, (p == 1) ? 32'h44 : 32'h04);
      cyc(120);
      rd(COUNT_OFFSET);
      chk(inr((p == 1) ? 120 : 9, (p == 1) ? 135 : 12, d), 32'h1);
    end
    $display("test prescale done");
    r = $urandom_range(32'hff00, 0);
    k = $urandom_range(6, 1);
    wr(CONTROL_OFFSET, 32'h07);
    wr(COUNT_OFFSET, r);
    repeat (k) pin_fall(1'b0);
    rchk(COUNT_OFFSET, r + k);
    pin_fall(1'b1);
    rchk(STATUS_OFFSET, 32'h0);
    rchk(RELOAD_OFFSET, 32'h0);
    wr(CONTROL_OFFSET, 32'h0f);
    pin_fall(1'b1);
    rchk(RELOAD_OFFSET, r + k);
    cyc(20);
    rchk(STATUS_OFFSET, 32'h2);
    $display("test capture done");
    r = $urandom_range(32'hfff0, 0);
    wr(CONTROL_OFFSET, 32'h0e);
    wr(RELOAD_OFFSET, r);
    wr(MASK_OFFSET, 32'h2);
    wr(STATUS_OFFSET, 32'h3);
    chk(32'(irq), 32'h0);
    wr(COUNT_OFFSET, 32'h1234);
    pin_fall(1'b1);
    rchk(COUNT_OFFSET, r);
    chk(32'(irq), 32'h1);
    wr(STATUS_OFFSET, 32'h3);
    wr(MASK_OFFSET, 32'h1);
    k = adc_n;
    wr(COUNT_OFFSET, 32'hffff);
    pin_fall(1'b0);
    rchk(COUNT_OFFSET, r);
    rchk(STATUS_OFFSET, 32'h1);
    chk(32'(irq), 32'h1);
    chk(adc_n - k, 32'h1);
    wr(MASK_OFFSET, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(MASK_OFFSET, 32'h1);
    wr(STATUS_OFFSET, 32'h1);
    cyc(2);
    chk(32'(irq), 32'h0);
    $display("test reload done");
    wr(RELOAD_OFFSET, 32'hfffd);
    for (int b = 0; b < 2; b++) begin
      // capture select stays set to show that baud mode overrides it
      wr(CONTROL_OFFSET, (b == 1) ? 32'h27 : 32'h17);
      wr(COUNT_OFFSET, 32'hfffd);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      repeat (9) pin_fall(1'b0);
      chk(32'(txn), (b == 1) ? 32'h0 : ticks(9, 16'hfffd));
      chk(32'(rxn), (b == 1) ? ticks(9, 16'hfffd) : 32'h0);
      rchk(STATUS_OFFSET, 32'h0);
      rchk(COUNT_OFFSET, 32'hfffd);
    end
    wr(CONTROL_OFFSET, 32'h1f);
    pin_fall(1'b1);
    rchk(STATUS_OFFSET, 32'h2);
    wr(STATUS_OFFSET, 32'h3);
    wr(RELOAD_OFFSET, 32'hfff0);
    wr(COUNT_OFFSET, 32'hfff0);
    wr(CONTROL_OFFSET, 32'h14);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(640);
    chk(inr(19, 21, {16'h0000, txn}), 32'h1);
    $display("test baud done");
    results();
  end
endmodule : tb
`default_nettype wire
